// ---- pkg/oc_map.vh ----
/*
 * Register map, field positions, reset values and filter constants of the
 * overcurrent comparator block.
 * Assumes a 4-bit word address and 16-bit data on the register port.
 */
`ifndef OC_MAP_VH
`define OC_MAP_VH

// ----------------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------------
`define OC_ADDR_CTRL        4'h0
`define OC_ADDR_CFG_A       4'h1
`define OC_ADDR_HIGH_TH_A   4'h2
`define OC_ADDR_LOW_TH_A    4'h3
`define OC_ADDR_CFG_B       4'h4
`define OC_ADDR_HIGH_TH_B   4'h5
`define OC_ADDR_LOW_TH_B    4'h6
`define OC_ADDR_STATUS      4'h7
`define OC_ADDR_FAULT_MASK  4'h8
`define OC_ADDR_MAIN_STATUS 4'h9
`define OC_ADDR_PIN_CFG     4'hA
`define OC_ADDR_IRQ_STATUS  4'hB
`define OC_ADDR_IRQ_ENABLE  4'hC
`define OC_ADDR_RESULT_A    4'hD
`define OC_ADDR_RESULT_B    4'hE

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define OC_CTRL_CMP_EN_A    0
`define OC_CTRL_CMP_EN_B    1
`define OC_CTRL_CONV_EN_A   2
`define OC_CTRL_CONV_EN_B   3
`define OC_PIN_DIR          0
`define OC_PIN_SRC          1
`define OC_PIN_FMT          2
`define OC_PIN_POL          3
`define OC_PIN_DATA         4
`define OC_PIN4_BASE        8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define OC_RST_CTRL         4'h0
`define OC_RST_CFG          5'h00
`define OC_RST_HIGH_TH      16'h7FFF
`define OC_RST_LOW_TH       16'h8000
`define OC_RST_STATUS       4'hF
`define OC_RST_MASK         4'h0
`define OC_RST_PIN_CFG      13'h0000
`define OC_RST_IRQ          4'h0

// ----------------------------------------------------------------------
// Fast filter
// ----------------------------------------------------------------------
`define OC_OSR              64
`define OC_PHASE_LAST       6'h3F
`define OC_SETTLE_OUTPUTS   2'h2
`define OC_SINC_MID         20'h20000
`define OC_COUNT_MAX        5'h1F
`define OC_PWM_HALF         256

`endif

// ---- src/oc_overcurrent_comparator.v ----
/*
 * Two digital overcurrent comparators: sinc3 fast filters, threshold
 * checks, consecutive-exceedance counters, latched fault flags, combined
 * fault flag, interrupt and two fault pins.
 * Assumes the modulator bitstreams are produced on i_clk, one bit a clock,
 * and a register master that follows the plain strobe port protocol.
 */
// Chosen here: the register offsets and the plain strobed port.
// Functional notes
// RQ1: Each comparator runs its own sinc3 filter, fixed ratio 64, on the bitstream.
// RQ2: No offset or gain correction is applied to comparator results.
// RQ3: Comparator runs only while its current converter enable is set.
// RQ4: Filter starts once comparator enable and its converter enable are both set.
// RQ5: 16-bit result above high or below low threshold counts as exceedance.
// RQ6: High threshold 7FFF disables high-side detection.
// RQ7: Low threshold 8000 disables low-side detection.
// RQ8: Five-bit count sets consecutive exceedances needed; zero means one.
// RQ9: Counter clears on an in-range result or when comparator is disabled.
// RQ10: Combined fault flag goes low when any unmasked detailed flag is low.
// RQ11: Combined flag write-one clear ignored while any detailed flag is low.
// RQ12: Mask bit keeps detailed flag from combined flag, flag still records.
// RQ13: Host disables comparator before changing its configuration or thresholds.
// RQ14: Pin 3/4 show comparator A/B fault when output and source zero.
// RQ15: Fault pin active when high or low flag low; mask ignored.
// RQ16: Per-pin format and polarity bits shape active and inactive waveform.
// RQ17: Large overshoot trips in one 64-clock period, marginal in four.
// RQ18: Detailed flags stay low until host writes one to clear them.
`timescale 1ns/1ps
`include "oc_map.vh"

// ----------------------------------------------------------------------
// One comparator channel: fast filter, compare, exceedance counter
// ----------------------------------------------------------------------
module oc_channel (
  input  wire        i_clk,
  input  wire        i_reset,
  input  wire        i_run,
  input  wire        i_mod_bit,
  input  wire [15:0] i_high_th,
  input  wire [15:0] i_low_th,
  input  wire [4:0]  i_count_set,
  output wire [15:0] o_result,
  output wire        o_high_evt,
  output wire        o_low_evt
);
  reg  [19:0] int1_r;
  reg  [19:0] int2_r;
  reg  [19:0] int3_r;
  reg  [19:0] dly1_r;
  reg  [19:0] dly2_r;
  reg  [19:0] dly3_r;
  reg  [5:0]  phase_r;
  reg  [1:0]  settle_r;
  reg  [4:0]  exceed_r;
  reg  [15:0] result_r;
  reg         high_evt_r;
  reg         low_evt_r;
  reg  [19:0] comb1;
  reg  [19:0] comb2;
  reg  [19:0] comb3;
  reg  [19:0] centered;
  reg  [15:0] sample;
  reg         above;
  reg         below;
  wire        decimate;
  assign decimate   = (phase_r == `OC_PHASE_LAST);
  assign o_result   = result_r;
  assign o_high_evt = high_evt_r;
  assign o_low_evt  = low_evt_r;
  // Comb section and scaling to a signed 16-bit code
  always @* begin
    comb1    = int3_r - dly1_r;
    comb2    = comb1 - dly2_r;
    comb3    = comb2 - dly3_r;
    centered = comb3 - `OC_SINC_MID;
    // RQ2: raw code only
    if (!centered[19] && (centered[18:17] != 2'b00)) begin
      sample = 16'h7FFF;
    end else begin
      sample = centered[17:2];
    end
    // RQ5: two-sided compare
    // RQ6: 7FFF never exceeded
    // RQ7: 8000 never undercut
    above = ($signed(sample) > $signed(i_high_th));
    below = ($signed(sample) < $signed(i_low_th));
  end
  // RQ1: sinc3 integrators, ratio 64
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      int1_r     <= 20'h00000;
      int2_r     <= 20'h00000;
      int3_r     <= 20'h00000;
      dly1_r     <= 20'h00000;
      dly2_r     <= 20'h00000;
      dly3_r     <= 20'h00000;
      phase_r    <= 6'h00;
      settle_r   <= 2'h0;
      exceed_r   <= 5'h00;
      result_r   <= 16'h0000;
      high_evt_r <= 1'b0;
      low_evt_r  <= 1'b0;
    end else if (!i_run) begin
      // RQ9: disable clears counter
      int1_r     <= 20'h00000;
      int2_r     <= 20'h00000;
      int3_r     <= 20'h00000;
      dly1_r     <= 20'h00000;
      dly2_r     <= 20'h00000;
      dly3_r     <= 20'h00000;
      phase_r    <= 6'h00;
      settle_r   <= 2'h0;
      exceed_r   <= 5'h00;
      high_evt_r <= 1'b0;
      low_evt_r  <= 1'b0;
    end else begin
      // RQ4: runs whenever enabled
      int1_r     <= int1_r + {19'h00000, i_mod_bit};
      int2_r     <= int2_r + int1_r;
      int3_r     <= int3_r + int2_r;
      phase_r    <= phase_r + 6'h01;
      high_evt_r <= 1'b0;
      low_evt_r  <= 1'b0;
      if (decimate) begin
        dly1_r <= int3_r;
        dly2_r <= comb1;
        dly3_r <= comb2;
        // Unsettled start-up outputs are hidden
        if (settle_r != `OC_SETTLE_OUTPUTS) begin
          settle_r <= settle_r + 2'h1;
        end else begin
          // RQ17: one decision per 64 clocks
          result_r <= sample;
          if (above || below) begin
            // RQ8: trip after setting plus one results
            if (exceed_r >= i_count_set) begin
              high_evt_r <= above;
              low_evt_r  <= below;
            end
            if (exceed_r != `OC_COUNT_MAX) begin
              exceed_r <= exceed_r + 5'h01;
            end
          end else begin
            // RQ9: in-range result clears
            exceed_r <= 5'h00;
          end
        end
      end
    end
  end
endmodule

// ----------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------
module oc_overcurrent_comparator #(
  parameter PWM_HALF = `OC_PWM_HALF
) (
  input  wire        i_clk,
  input  wire        i_reset,
  input  wire        i_mod_bit_a,
  input  wire        i_mod_bit_b,
  input  wire [3:0]  i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output wire [15:0] o_rdata,
  output wire        o_irq,
  output wire        o_conv_en_a,
  output wire        o_conv_en_b,
  output wire        o_pin3_out,
  output wire        o_pin3_oe_n,
  output wire        o_pin4_out,
  output wire        o_pin4_oe_n
);
  reg  [3:0]  ctrl_r;
  reg  [4:0]  cfg_a_r;
  reg  [15:0] high_th_a_r;
  reg  [15:0] low_th_a_r;
  reg  [4:0]  cfg_b_r;
  reg  [15:0] high_th_b_r;
  reg  [15:0] low_th_b_r;
  reg  [3:0]  status_r;
  reg  [3:0]  status_nxt;
  reg  [3:0]  mask_r;
  reg         fault_n_r;
  reg         fault_n_nxt;
  reg  [12:0] pin_cfg_r;
  reg  [3:0]  irq_status_r;
  reg  [3:0]  irq_status_nxt;
  reg  [3:0]  irq_enable_r;
  reg  [15:0] rdata_r;
  reg  [15:0] rdata_nxt;
  reg  [8:0]  pwm_cnt_r;
  reg         pwm_r;
  reg         pin3_r;
  reg         pin4_r;
  reg         pin3_oe_n_r;
  reg         pin4_oe_n_r;
  wire [15:0] result_a;
  wire [15:0] result_b;
  wire [3:0]  evt;
  wire        run_a;
  wire        run_b;
  wire        fault_a;
  wire        fault_b;
  wire [4:0]  p3;
  wire [4:0]  p4;
  // RQ3: comparator needs its converter enabled
  assign run_a = ctrl_r[`OC_CTRL_CMP_EN_A] & ctrl_r[`OC_CTRL_CONV_EN_A];
  assign run_b = ctrl_r[`OC_CTRL_CMP_EN_B] & ctrl_r[`OC_CTRL_CONV_EN_B];
  assign o_conv_en_a = ctrl_r[`OC_CTRL_CONV_EN_A];
  assign o_conv_en_b = ctrl_r[`OC_CTRL_CONV_EN_B];
  oc_channel u_chan_a (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_run       (run_a),
    .i_mod_bit   (i_mod_bit_a),
    .i_high_th   (high_th_a_r),
    .i_low_th    (low_th_a_r),
    .i_count_set (cfg_a_r),
    .o_result    (result_a),
    .o_high_evt  (evt[0]),
    .o_low_evt   (evt[1])
  );
  oc_channel u_chan_b (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_run       (run_b),
    .i_mod_bit   (i_mod_bit_b),
    .i_high_th   (high_th_b_r),
    .i_low_th    (low_th_b_r),
    .i_count_set (cfg_b_r),
    .o_result    (result_b),
    .o_high_evt  (evt[2]),
    .o_low_evt   (evt[3])
  );
  // ----------------------------------------------------------------------
  // Flags: set wins over a simultaneous clear
  // ----------------------------------------------------------------------
  always @* begin
    status_nxt     = status_r;
    irq_status_nxt = irq_status_r;
    fault_n_nxt    = fault_n_r;
    if (i_wr && (i_addr == `OC_ADDR_STATUS)) begin
      status_nxt = status_r | i_wdata[3:0];
    end
    if (i_wr && (i_addr == `OC_ADDR_IRQ_STATUS)) begin
      irq_status_nxt = irq_status_r & ~i_wdata[3:0];
    end
    // RQ18: latched until written one
    status_nxt     = status_nxt & ~evt;
    irq_status_nxt = irq_status_nxt | evt;
    // RQ11: clear only with all detailed flags high
    if (i_wr && (i_addr == `OC_ADDR_MAIN_STATUS) && i_wdata[0] && (&status_r)) begin
      fault_n_nxt = 1'b1;
    end
    // RQ10: unmasked low flag drives combined low
    // RQ12: masked flags excluded
    if (|(~status_nxt & ~mask_r)) begin
      fault_n_nxt = 1'b0;
    end
  end
  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_r       <= `OC_RST_CTRL;
      cfg_a_r      <= `OC_RST_CFG;
      high_th_a_r  <= `OC_RST_HIGH_TH;
      low_th_a_r   <= `OC_RST_LOW_TH;
      cfg_b_r      <= `OC_RST_CFG;
      high_th_b_r  <= `OC_RST_HIGH_TH;
      low_th_b_r   <= `OC_RST_LOW_TH;
      status_r     <= `OC_RST_STATUS;
      mask_r       <= `OC_RST_MASK;
      fault_n_r    <= 1'b1;
      pin_cfg_r    <= `OC_RST_PIN_CFG;
      irq_status_r <= `OC_RST_IRQ;
      irq_enable_r <= `OC_RST_IRQ;
    end else begin
      status_r     <= status_nxt;
      irq_status_r <= irq_status_nxt;
      fault_n_r    <= fault_n_nxt;
      if (i_wr) begin
        if (i_addr == `OC_ADDR_CTRL) begin
          ctrl_r <= i_wdata[3:0];
        end else if (i_addr == `OC_ADDR_CFG_A) begin
          cfg_a_r <= i_wdata[4:0];
        end else if (i_addr == `OC_ADDR_HIGH_TH_A) begin
          high_th_a_r <= i_wdata;
        end else if (i_addr == `OC_ADDR_LOW_TH_A) begin
          low_th_a_r <= i_wdata;
        end else if (i_addr == `OC_ADDR_CFG_B) begin
          cfg_b_r <= i_wdata[4:0];
        end else if (i_addr == `OC_ADDR_HIGH_TH_B) begin
          high_th_b_r <= i_wdata;
        end else if (i_addr == `OC_ADDR_LOW_TH_B) begin
          low_th_b_r <= i_wdata;
        end else if (i_addr == `OC_ADDR_FAULT_MASK) begin
          mask_r <= i_wdata[3:0];
        end else if (i_addr == `OC_ADDR_PIN_CFG) begin
          pin_cfg_r <= i_wdata[12:0];
        end else if (i_addr == `OC_ADDR_IRQ_ENABLE) begin
          irq_enable_r <= i_wdata[3:0];
        end
      end
    end
  end
  // ----------------------------------------------------------------------
  // Register reads: data in the cycle after the strobe only
  // ----------------------------------------------------------------------
  always @* begin
    rdata_nxt = 16'h0000;
    if (i_rd) begin
      if (i_addr == `OC_ADDR_CTRL) begin
        rdata_nxt = {12'h000, ctrl_r};
      end else if (i_addr == `OC_ADDR_CFG_A) begin
        rdata_nxt = {11'h000, cfg_a_r};
      end else if (i_addr == `OC_ADDR_HIGH_TH_A) begin
        rdata_nxt = high_th_a_r;
      end else if (i_addr == `OC_ADDR_LOW_TH_A) begin
        rdata_nxt = low_th_a_r;
      end else if (i_addr == `OC_ADDR_CFG_B) begin
        rdata_nxt = {11'h000, cfg_b_r};
      end else if (i_addr == `OC_ADDR_HIGH_TH_B) begin
        rdata_nxt = high_th_b_r;
      end else if (i_addr == `OC_ADDR_LOW_TH_B) begin
        rdata_nxt = low_th_b_r;
      end else if (i_addr == `OC_ADDR_STATUS) begin
        rdata_nxt = {12'h000, status_r};
      end else if (i_addr == `OC_ADDR_FAULT_MASK) begin
        rdata_nxt = {12'h000, mask_r};
      end else if (i_addr == `OC_ADDR_MAIN_STATUS) begin
        rdata_nxt = {15'h0000, fault_n_r};
      end else if (i_addr == `OC_ADDR_PIN_CFG) begin
        rdata_nxt = {3'h0, pin_cfg_r};
      end else if (i_addr == `OC_ADDR_IRQ_STATUS) begin
        rdata_nxt = {12'h000, irq_status_r};
      end else if (i_addr == `OC_ADDR_IRQ_ENABLE) begin
        rdata_nxt = {12'h000, irq_enable_r};
      end else if (i_addr == `OC_ADDR_RESULT_A) begin
        rdata_nxt = result_a;
      end else if (i_addr == `OC_ADDR_RESULT_B) begin
        rdata_nxt = result_b;
      end
    end
  end
  assign o_rdata = rdata_r;
  assign o_irq   = |(irq_status_r & irq_enable_r);
  // ----------------------------------------------------------------------
  // Fault pins
  // ----------------------------------------------------------------------
  // RQ15: flags only, mask not used
  assign fault_a = ~status_r[0] | ~status_r[1];
  assign fault_b = ~status_r[2] | ~status_r[3];
  assign p3      = pin_cfg_r[4:0];
  assign p4      = pin_cfg_r[`OC_PIN4_BASE+4:`OC_PIN4_BASE];
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_r     <= 16'h0000;
      pwm_cnt_r   <= 9'h000;
      pwm_r       <= 1'b0;
      pin3_r      <= 1'b0;
      pin4_r      <= 1'b0;
      pin3_oe_n_r <= 1'b1;
      pin4_oe_n_r <= 1'b1;
    end else begin
      rdata_r <= rdata_nxt;
      // Heartbeat divider for the inactive waveform
      if (pwm_cnt_r == PWM_HALF[8:0] - 9'h001) begin
        pwm_cnt_r <= 9'h000;
        pwm_r     <= ~pwm_r;
      end else begin
        pwm_cnt_r <= pwm_cnt_r + 9'h001;
      end
      // RQ14: output direction and comparator source
      pin3_oe_n_r <= ~p3[`OC_PIN_DIR];
      pin4_oe_n_r <= ~p4[`OC_PIN_DIR];
      // RQ16: polarity sets active level, format the inactive one
      if (p3[`OC_PIN_SRC]) begin
        pin3_r <= p3[`OC_PIN_DATA];
      end else if (fault_a) begin
        pin3_r <= p3[`OC_PIN_POL];
      end else begin
        pin3_r <= p3[`OC_PIN_FMT] ? pwm_r : ~p3[`OC_PIN_POL];
      end
      if (p4[`OC_PIN_SRC]) begin
        pin4_r <= p4[`OC_PIN_DATA];
      end else if (fault_b) begin
        pin4_r <= p4[`OC_PIN_POL];
      end else begin
        pin4_r <= p4[`OC_PIN_FMT] ? pwm_r : ~p4[`OC_PIN_POL];
      end
    end
  end
  assign o_pin3_out  = pin3_r;
  assign o_pin3_oe_n = pin3_oe_n_r;
  assign o_pin4_out  = pin4_r;
  assign o_pin4_oe_n = pin4_oe_n_r;
endmodule

// ---- tb/oc_overcurrent_comparator_properties.sv ----
/*
 * Port-level properties of the overcurrent comparator top module.
 * Assumes binding to oc_overcurrent_comparator, single clock i_clk.
 */
`timescale 1ns/1ps
`include "oc_map.vh"
module oc_overcurrent_comparator_properties (
  input wire        i_clk,
  input wire        i_reset,
  input wire        i_mod_bit_a,
  input wire        i_mod_bit_b,
  input wire [3:0]  i_addr,
  input wire [15:0] i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [15:0] o_rdata,
  input wire        o_irq,
  input wire        o_conv_en_a,
  input wire        o_conv_en_b,
  input wire        o_pin3_out,
  input wire        o_pin3_oe_n,
  input wire        o_pin4_out,
  input wire        o_pin4_oe_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire ctrl_wr = i_wr && (i_addr == `OC_ADDR_CTRL);
  wire pin_wr  = i_wr && (i_addr == `OC_ADDR_PIN_CFG);
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  conv_a_follow_a: assert property (
    ctrl_wr |=> o_conv_en_a == $past(i_wdata[`OC_CTRL_CONV_EN_A]))
    else $error("converter A enable did not follow control write");
  conv_b_follow_a: assert property (
    ctrl_wr |=> o_conv_en_b == $past(i_wdata[`OC_CTRL_CONV_EN_B]))
    else $error("converter B enable did not follow control write");
  conv_en_hold_a: assert property (
    !ctrl_wr |=> $stable({o_conv_en_a, o_conv_en_b}))
    else $error("converter enable changed without control write");
  irq_fall_cause_a: assert property (
    $fell(o_irq) |-> $past(i_wr))
    else $error("interrupt dropped without a host write");
  main_width_a: assert property (
    i_rd && (i_addr == `OC_ADDR_MAIN_STATUS) |=> o_rdata[15:1] == 15'h0000)
    else $error("combined status upper bits not zero");
  pin3_dir_a: assert property (
    pin_wr ##1 !pin_wr |=> o_pin3_oe_n == !$past(i_wdata[0], 2))
    else $error("pin3 enable does not follow direction bit");
  pin4_dir_a: assert property (
    pin_wr ##1 !pin_wr |=> o_pin4_oe_n == !$past(i_wdata[8], 2))
    else $error("pin4 enable does not follow direction bit");
  pin3_src_a: assert property (
    pin_wr && (i_wdata[1:0] == 2'h3) ##1 !pin_wr |=> o_pin3_out == $past(i_wdata[4], 2))
    else $error("pin3 does not show data bit with source set");
  oe_quiet_a: assert property (
    !$past(pin_wr) && !$past(pin_wr, 2) |-> $stable(o_pin3_oe_n) && $stable(o_pin4_oe_n))
    else $error("pin enable changed without pin config write");
  cover property (o_irq);
  cover property ($fell(o_pin3_out));
  cover property ($fell(o_pin4_out));
endmodule

// ---- tb/oc_host_monitor.sv ----
/*
 * Host side of the fault pins: resolves each pin level.
 * Assumes a board pull-up on both pins.
 */
`timescale 1ns/1ps
module oc_host_monitor (
  input  wire       i_pin3_out,
  input  wire       i_pin3_oe_n,
  input  wire       i_pin4_out,
  input  wire       i_pin4_oe_n,
  output wire [1:0] o_pin_lvl
);
  // Released pin reads high through the pull-up
  assign o_pin_lvl = {i_pin4_oe_n | i_pin4_out, i_pin3_oe_n | i_pin3_out};
endmodule

// ---- tb/oc_overcurrent_comparator_tb.sv ----
/*
 * Self-checking bench of the overcurrent comparator.
 * Assumes the register map header and the host pin monitor.
 */
`timescale 1ns/1ps
`include "oc_map.vh"
module oc_overcurrent_comparator_tb;
  reg         i_clk, i_reset, i_mod_bit_a, i_mod_bit_b, i_wr, i_rd, rd_q;
  reg  [3:0]  i_addr;
  reg  [15:0] i_wdata, lf;
  reg  [1:0]  mode;
  wire [15:0] o_rdata;
  wire        o_irq, o_conv_en_a, o_conv_en_b;
  wire        o_pin3_out, o_pin3_oe_n, o_pin4_out, o_pin4_oe_n;
  wire [1:0]  pin_lvl;
  logic [15:0] exp_q[$];
  integer     errors, n_compared, ch, a;

  oc_overcurrent_comparator #(.PWM_HALF(4)) oc_overcurrent_comparator_i (
    .i_clk(i_clk), .i_reset(i_reset), .i_mod_bit_a(i_mod_bit_a), .i_mod_bit_b(i_mod_bit_b),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_conv_en_a(o_conv_en_a), .o_conv_en_b(o_conv_en_b),
    .o_pin3_out(o_pin3_out), .o_pin3_oe_n(o_pin3_oe_n), .o_pin4_out(o_pin4_out),
    .o_pin4_oe_n(o_pin4_oe_n));
  oc_host_monitor oc_host_monitor_i (.i_pin3_out(o_pin3_out), .i_pin3_oe_n(o_pin3_oe_n),
    .i_pin4_out(o_pin4_out), .i_pin4_oe_n(o_pin4_oe_n), .o_pin_lvl(pin_lvl));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  function [15:0] lfsr(input [15:0] x);
    lfsr = {1'b0, x[15:1]} ^ (x[0] ? 16'hB400 : 16'h0000);
  endfunction

  function [15:0] rst_of(input [3:0] ad);
    case (ad)
      4'h2, 4'h5: rst_of = `OC_RST_HIGH_TH;
      4'h3, 4'h6: rst_of = `OC_RST_LOW_TH;
      4'h7:       rst_of = {12'h000, `OC_RST_STATUS};
      4'h9:       rst_of = 16'h0001;
      default:    rst_of = 16'h0000;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Modulator streams: mode 0 random, 1 all ones, 2 all zeros
  // ----------------------------------------------------------------------
  always @(posedge i_clk) begin
    lf <= lfsr(lf);
    i_mod_bit_a <= (mode == 2'h1) | ((mode == 2'h0) & lf[0]);
    i_mod_bit_b <= (mode == 2'h1) | ((mode == 2'h0) & lf[7]);
  end

  task check(input string nm, input [15:0] seen, input [15:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Read data compared against the oldest note
  always @(posedge i_clk) begin
    if (rd_q) check("rdata", o_rdata, exp_q.pop_front());
    rd_q <= i_rd;
  end

  task wr(input [3:0] ad, input [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task rd(input [3:0] ad, input [15:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= ad;
    exp_q.push_back(e);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask

  task automatic waitc(input integer n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic pin_is(input integer c, input bit v);
    #1;
    check("pin level", 16'(pin_lvl[c]), 16'(v));
  endtask

  task give_verdict;
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // One comparator channel through disable, trip, clear and mask
  // ----------------------------------------------------------------------
  task automatic run_ch(input integer c);
    reg [3:0]  b;
    reg [15:0] en, hi, lo;
    integer    n;
    bit        l1;
    b = 4'(3 * c);
    en = (16'h0001 << c) | (16'h0004 << c);
    hi = 16'h0001 << (2 * c);
    lo = 16'h0002 << (2 * c);
    n = 2 - 2 * c;
    wr(b + 4'h1, n[15:0]);
    wr(`OC_ADDR_CTRL, en);
    mode <= 2'h1;
    waitc(400);
    mode <= 2'h2;
    waitc(400);
    rd(`OC_ADDR_STATUS, 16'h000F);
    wr(`OC_ADDR_CTRL, 16'h0000);
    wr(b + 4'h2, 16'h6000);
    wr(b + 4'h3, 16'hA000);
    wr(`OC_ADDR_CTRL, en & 16'h0003);
    mode <= 2'h1;
    waitc(400);
    rd(`OC_ADDR_STATUS, 16'h000F);
    wr(`OC_ADDR_CTRL, en);
    waitc(160 + 64 * n);
    rd(`OC_ADDR_STATUS, 16'h000F);
    wr(`OC_ADDR_CTRL, 16'h0000);
    wr(`OC_ADDR_CTRL, en);
    waitc(160 + 64 * n);
    rd(`OC_ADDR_STATUS, 16'h000F);
    waitc(60);
    rd(`OC_ADDR_STATUS, 16'h000F ^ hi);
    rd(`OC_ADDR_RESULT_A + c[3:0], 16'h7FFF);
    rd(`OC_ADDR_MAIN_STATUS, 16'h0000);
    pin_is(c, 1'b0);
    check("irq", 16'(o_irq), 16'h0001);
    mode <= 2'h0;
    waitc(300);
    rd(`OC_ADDR_STATUS, 16'h000F ^ hi);
    wr(`OC_ADDR_MAIN_STATUS, 16'h0001);
    rd(`OC_ADDR_MAIN_STATUS, 16'h0000);
    wr(`OC_ADDR_STATUS, hi);
    wr(`OC_ADDR_MAIN_STATUS, 16'h0001);
    rd(`OC_ADDR_MAIN_STATUS, 16'h0001);
    wr(`OC_ADDR_IRQ_STATUS, 16'h000F);
    pin_is(c, 1'b1);
    check("irq", 16'(o_irq), 16'h0000);
    wr(`OC_ADDR_FAULT_MASK, lo);
    mode <= 2'h2;
    waitc(450);
    rd(`OC_ADDR_STATUS, 16'h000F ^ lo);
    rd(`OC_ADDR_MAIN_STATUS, 16'h0001);
    pin_is(c, 1'b0);
    wr(`OC_ADDR_PIN_CFG, 16'h0909);
    waitc(2);
    pin_is(c, 1'b1);
    mode <= 2'h0;
    waitc(300);
    wr(`OC_ADDR_STATUS, 16'h000F);
    wr(`OC_ADDR_PIN_CFG, 16'h0505);
    waitc(2);
    #1 l1 = pin_lvl[c];
    waitc(4);
    pin_is(c, ~l1);
    wr(`OC_ADDR_PIN_CFG, 16'h0101);
    wr(`OC_ADDR_FAULT_MASK, 16'h0000);
    wr(`OC_ADDR_IRQ_STATUS, 16'h000F);
    wr(`OC_ADDR_CTRL, 16'h0000);
  endtask

  initial begin
    i_reset = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    rd_q = 1'b0;
    i_addr = 4'h0;
    i_wdata = 16'h0000;
    i_mod_bit_a = 1'b0;
    i_mod_bit_b = 1'b0;
    lf = 16'h4C81;
    mode = 2'h0;
    errors = 0;
    n_compared = 0;
    waitc(6);
    i_reset <= 1'b0;
    for (a = 0; a < 16; a = a + 1) begin
      if (a < 13 || a == 15) rd(a[3:0], rst_of(a[3:0]));
    end
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
    wr(`OC_ADDR_PIN_CFG, 16'h0003);
    waitc(2);
    pin_is(0, 1'b0);
    wr(`OC_ADDR_PIN_CFG, 16'h0101);
    wr(`OC_ADDR_IRQ_ENABLE, 16'h000F);
    for (ch = 0; ch < 2; ch = ch + 1) run_ch(ch);
    waitc(4);
    give_verdict;
  end

  initial begin
    repeat (30000) @(posedge i_clk);
    errors = errors + 1;
    give_verdict;
  end
endmodule

bind oc_overcurrent_comparator oc_overcurrent_comparator_properties
  oc_overcurrent_comparator_properties_i (
  .i_clk(i_clk), .i_reset(i_reset), .i_mod_bit_a(i_mod_bit_a), .i_mod_bit_b(i_mod_bit_b),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_irq(o_irq), .o_conv_en_a(o_conv_en_a), .o_conv_en_b(o_conv_en_b),
  .o_pin3_out(o_pin3_out), .o_pin3_oe_n(o_pin3_oe_n), .o_pin4_out(o_pin4_out),
  .o_pin4_oe_n(o_pin4_oe_n));
